// ==== rtl/irq_enable_map.svh ====
// Offsets, bit positions and reset values of the interrupt enable block
`ifndef IRQ_ENABLE_MAP_SVH
`define IRQ_ENABLE_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_GLOBAL_CONTROL 8'h00
`define OFS_CORE_ENABLES 8'h04
`define OFS_PERIPH_ENABLES_ONE 8'h08
`define OFS_PERIPH_ENABLES_TWO 8'h0C
`define OFS_CORE_FLAGS 8'h10
`define OFS_PERIPH_FLAGS_ONE 8'h14
`define OFS_PERIPH_FLAGS_TWO 8'h18

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_GLOBAL_IRQ_ENABLE 7
`define BIT_PERIPHERAL_GROUP_ENABLE 6
`define BIT_EXT_EDGE_SELECT 0
`define BIT_TIMER_ZERO 5
`define BIT_PIN_CHANGE 4
`define BIT_EXT_PIN 0

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define RST_ENABLE 1'b0
`define RST_EXT_EDGE_SELECT 1'b1
`define RST_BYTE 8'h00
`define IRQ_VECTOR_ADDR 16'h0004
`define HTRANS_NONSEQ_BIT 1
`define REG_DATA_WIDTH 8

`endif

// ==== rtl/irq_enable_pkg.sv ====
// Types shared by the interrupt enable block
package irq_enable_pkg;

    // Sources of the first peripheral group, msb first
    typedef struct packed {
        logic timer_one_gate;
        logic converter_done;
        logic serial_receive;
        logic serial_transmit;
        logic sync_port_one;
        logic sync_port_one_collision;
        logic timer_two_match;
        logic timer_one_overflow;
    } periph_one_t;

    // Sources of the second peripheral group, msb first
    typedef struct packed {
        logic timer_six_match;
        logic comparator_two;
        logic comparator_one;
        logic nonvolatile_done;
        logic sync_port_two;
        logic sync_port_two_collision;
        logic timer_four_match;
        logic accumulator_rollover;
    } periph_two_t;

    // Core-class sources
    typedef struct packed {
        logic timer_zero_overflow;
        logic pin_change;
        logic ext_pin;
    } core_src_t;

    // Bus slave data phase, Gray coded
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_READ_WAIT = 2'b11,
        BUS_READ_DONE = 2'b10
    } bus_state_t;

    typedef struct packed {
        bus_state_t bus;
        logic [7:0] addr;
        logic [31:0] rdata;
        logic global_irq_enable;
        logic peripheral_group_enable;
        logic ext_edge_select;
        core_src_t core_en;
        periph_one_t pe_one;
        periph_two_t pe_two;
        logic timer_zero_flag;
        logic ext_pin_flag;
        periph_one_t pf_one;
        periph_two_t pf_two;
        logic ext_pin_prev;
    } state_t;

endpackage

// ==== rtl/interrupt_enable_control.sv ====
// Interrupt global control, enable registers, flags and request to the core
//
// Behaviour
// - Global enable bit 7 passes enabled interrupts when 1, blocks all when 0.
// - Peripheral group enable bit 6 must be 1 to forward peripheral interrupts.
// - Edge select bit 0 at 1 makes rising external edge the trigger.
// - Unimplemented control and core enable bits ignore writes, read zero.
// - Reset clears all enables; edge select resets to one.
// - Core enable bit 5 gates timer-zero overflow interrupt.
// - Core enable bit 4 gates pin change-detect interrupt.
// - Core enable bit 0 gates external pin interrupt; pin chosen elsewhere.
// - First peripheral enables: bit 7 timer-one gate, bit 6 converter done.
// - First peripheral enables: bit 5 serial receive, bit 4 serial transmit.
// - First peripheral enables: bit 3 sync port one, bit 2 its collision.
// - First peripheral enables: bit 1 timer-two match, bit 0 timer-one overflow.
// - Second peripheral enables: bit 7 timer-six match, bit 6 comparator two.
// - Second peripheral enables: bit 5 comparator one, bit 4 nonvolatile done.
// - Second peripheral enables: bit 3 sync port two, bit 2 its collision.
// - Second peripheral enables: bit 1 timer-four match, bit 0 accumulator rollover.
// - Global enable set/cleared by software and hardware; group enable software only.
// - Edge select at 0 makes falling external edge the trigger.
// - Flags set on their events regardless of any enable.
// - Taken request clears global enable; core branches to fixed vector.
// - Handler return sets global enable again through hardware path.

`include "irq_enable_map.svh"

module interrupt_enable_control
    import irq_enable_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Event sources
    input wire logic timer_zero_event,
    input wire logic pin_change_pending,
    input wire logic ext_pin_level,
    input wire periph_one_t periph_one_events,
    input wire periph_two_t periph_two_events,
    // Core sequencer
    input wire logic irq_taken,
    input wire logic handler_return,
    output logic irq_request,
    output logic [15:0] irq_vector
);

    state_t state_reg;
    state_t state_next;

    logic addr_phase;
    logic wr_commit;
    logic [7:0] wdata;
    logic [31:0] read_mux;
    logic ext_edge;
    logic [7:0] clr_core;
    periph_one_t clr_one;
    periph_two_t clr_two;
    logic core_pending;
    logic periph_pending;
    logic one_pending;
    logic two_pending;
    periph_one_t pf_one_next;
    periph_two_t pf_two_next;
    logic timer_zero_flag_next;
    logic ext_pin_flag_next;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    assign addr_phase = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];
    assign wr_commit = (state_reg.bus == BUS_WRITE);
    assign wdata = hwdata[`REG_DATA_WIDTH-1:0];

    // Reads take one wait state so a write just before is always seen
    assign hreadyout = (state_reg.bus != BUS_READ_WAIT);
    assign hresp = 1'b0;
    assign hrdata = state_reg.rdata;
    assign irq_vector = `IRQ_VECTOR_ADDR;

    // ****************************************************************
    // Read mux
    // ****************************************************************
    always_comb begin
        read_mux = 32'h0000_0000;
        case (state_reg.addr)
            `OFS_GLOBAL_CONTROL: begin
                read_mux[`BIT_GLOBAL_IRQ_ENABLE] = state_reg.global_irq_enable;
                read_mux[`BIT_PERIPHERAL_GROUP_ENABLE] = state_reg.peripheral_group_enable;
                read_mux[`BIT_EXT_EDGE_SELECT] = state_reg.ext_edge_select;
            end
            `OFS_CORE_ENABLES: begin
                read_mux[`BIT_TIMER_ZERO] = state_reg.core_en.timer_zero_overflow;
                read_mux[`BIT_PIN_CHANGE] = state_reg.core_en.pin_change;
                read_mux[`BIT_EXT_PIN] = state_reg.core_en.ext_pin;
            end
            `OFS_PERIPH_ENABLES_ONE: begin
                read_mux[7:0] = state_reg.pe_one;
            end
            `OFS_PERIPH_ENABLES_TWO: begin
                read_mux[7:0] = state_reg.pe_two;
            end
            `OFS_CORE_FLAGS: begin
                read_mux[`BIT_TIMER_ZERO] = state_reg.timer_zero_flag;
                read_mux[`BIT_PIN_CHANGE] = pin_change_pending;
                read_mux[`BIT_EXT_PIN] = state_reg.ext_pin_flag;
            end
            `OFS_PERIPH_FLAGS_ONE: begin
                read_mux[7:0] = state_reg.pf_one;
            end
            `OFS_PERIPH_FLAGS_TWO: begin
                read_mux[7:0] = state_reg.pf_two;
            end
            default: begin
                read_mux = 32'h0000_0000;
            end
        endcase
    end

    // ****************************************************************
    // External pin edge
    // ****************************************************************
    always_comb begin
        if (state_reg.ext_edge_select) begin
            ext_edge = ext_pin_level & ~state_reg.ext_pin_prev;
        end else begin
            ext_edge = ~ext_pin_level & state_reg.ext_pin_prev;
        end
    end

    // ****************************************************************
    // Write-one-to-clear masks for the flags
    // ****************************************************************
    always_comb begin
        clr_core = `RST_BYTE;
        clr_one = `RST_BYTE;
        clr_two = `RST_BYTE;
        if (wr_commit) begin
            case (state_reg.addr)
                `OFS_CORE_FLAGS: clr_core = wdata;
                `OFS_PERIPH_FLAGS_ONE: clr_one = wdata;
                `OFS_PERIPH_FLAGS_TWO: clr_two = wdata;
                default: begin
                    clr_core = `RST_BYTE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Request to the core
    // ****************************************************************
    always_comb begin
        core_pending = (state_reg.core_en.timer_zero_overflow & state_reg.timer_zero_flag)
            | (state_reg.core_en.pin_change & pin_change_pending)
            | (state_reg.core_en.ext_pin & state_reg.ext_pin_flag);
        periph_pending = state_reg.peripheral_group_enable &
            (one_pending | two_pending);
        irq_request = state_reg.global_irq_enable & (core_pending | periph_pending);
    end

    // ****************************************************************
    // Enabled flags per peripheral group
    // ****************************************************************
    enabled_pending #(
        .WIDTH(`REG_DATA_WIDTH)
    ) one_gate (
        .enables(state_reg.pe_one),
        .flags(state_reg.pf_one),
        .pending(one_pending)
    );

    enabled_pending #(
        .WIDTH(`REG_DATA_WIDTH)
    ) two_gate (
        .enables(state_reg.pe_two),
        .flags(state_reg.pf_two),
        .pending(two_pending)
    );

    // ****************************************************************
    // Flag updates
    // ****************************************************************
    sticky_flag_update #(
        .WIDTH(`REG_DATA_WIDTH)
    ) one_flags (
        .flags(state_reg.pf_one),
        .clear(clr_one),
        .events(periph_one_events),
        .flags_next(pf_one_next)
    );

    sticky_flag_update #(
        .WIDTH(`REG_DATA_WIDTH)
    ) two_flags (
        .flags(state_reg.pf_two),
        .clear(clr_two),
        .events(periph_two_events),
        .flags_next(pf_two_next)
    );

    sticky_flag_update #(
        .WIDTH(1)
    ) timer_zero_flag_upd (
        .flags(state_reg.timer_zero_flag),
        .clear(clr_core[`BIT_TIMER_ZERO]),
        .events(timer_zero_event),
        .flags_next(timer_zero_flag_next)
    );

    // Pin change is a live level from its own block, so it has no flag here
    sticky_flag_update #(
        .WIDTH(1)
    ) ext_pin_flag_upd (
        .flags(state_reg.ext_pin_flag),
        .clear(clr_core[`BIT_EXT_PIN]),
        .events(ext_edge),
        .flags_next(ext_pin_flag_next)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        state_next.ext_pin_prev = ext_pin_level;

        // Bus data phase
        case (state_reg.bus)
            BUS_IDLE, BUS_WRITE, BUS_READ_DONE: begin
                if (addr_phase) begin
                    state_next.addr = haddr[7:0];
                    state_next.bus = hwrite ? BUS_WRITE : BUS_READ_WAIT;
                end else begin
                    state_next.bus = BUS_IDLE;
                end
            end
            BUS_READ_WAIT: begin
                state_next.rdata = read_mux;
                state_next.bus = BUS_READ_DONE;
            end
            default: begin
                state_next.bus = BUS_IDLE;
            end
        endcase
        // Unmapped addresses read zero; bits above haddr[7:0] must be zero
        if (addr_phase && (haddr[31:8] != 24'h00_0000)) begin
            state_next.addr = 8'hFF;
        end

        // Software writes to control and enables
        if (wr_commit) begin
            case (state_reg.addr)
                `OFS_GLOBAL_CONTROL: begin
                    state_next.global_irq_enable = wdata[`BIT_GLOBAL_IRQ_ENABLE];
                    state_next.peripheral_group_enable = wdata[`BIT_PERIPHERAL_GROUP_ENABLE];
                    state_next.ext_edge_select = wdata[`BIT_EXT_EDGE_SELECT];
                end
                `OFS_CORE_ENABLES: begin
                    state_next.core_en.timer_zero_overflow = wdata[`BIT_TIMER_ZERO];
                    state_next.core_en.pin_change = wdata[`BIT_PIN_CHANGE];
                    state_next.core_en.ext_pin = wdata[`BIT_EXT_PIN];
                end
                `OFS_PERIPH_ENABLES_ONE: state_next.pe_one = wdata;
                `OFS_PERIPH_ENABLES_TWO: state_next.pe_two = wdata;
                default: begin
                    state_next.pe_one = state_reg.pe_one;
                end
            endcase
        end

        // Hardware paths override a software write in the same cycle; irq_taken does so only while global enable is 1
        if (irq_taken && state_reg.global_irq_enable) begin
            state_next.global_irq_enable = 1'b0;
        end
        if (handler_return) begin
            state_next.global_irq_enable = 1'b1;
        end

        // Flags: an event in the clearing cycle wins over the clear
        state_next.timer_zero_flag = timer_zero_flag_next;
        state_next.ext_pin_flag = ext_pin_flag_next;
        state_next.pf_one = pf_one_next;
        state_next.pf_two = pf_two_next;
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg.bus <= BUS_IDLE;
            state_reg.addr <= `RST_BYTE;
            state_reg.rdata <= 32'h0000_0000;
            state_reg.global_irq_enable <= `RST_ENABLE;
            state_reg.peripheral_group_enable <= `RST_ENABLE;
            state_reg.ext_edge_select <= `RST_EXT_EDGE_SELECT;
            state_reg.core_en <= '0;
            state_reg.pe_one <= `RST_BYTE;
            state_reg.pe_two <= `RST_BYTE;
            state_reg.timer_zero_flag <= 1'b0;
            state_reg.ext_pin_flag <= 1'b0;
            state_reg.pf_one <= `RST_BYTE;
            state_reg.pf_two <= `RST_BYTE;
            // Idle level assumed high so a high pin gives no false rising edge at start
            state_reg.ext_pin_prev <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule // interrupt_enable_control

// ****************************************************************
// Helper: sticky flag update
// ****************************************************************
// An event in the clearing cycle wins, so no event is lost to a clear
module sticky_flag_update #(
    parameter int WIDTH = 8
) (
    // Current flags and write-one-to-clear mask
    input wire logic [WIDTH-1:0] flags,
    input wire logic [WIDTH-1:0] clear,
    // Events of this cycle
    input wire logic [WIDTH-1:0] events,
    // Next flags
    output logic [WIDTH-1:0] flags_next
);

    always_comb begin
        flags_next = (flags & ~clear) | events;
    end

endmodule // sticky_flag_update

// ****************************************************************
// Helper: enabled flags of one group
// ****************************************************************
// Purely combinational; the group and global gates are applied outside
module enabled_pending #(
    parameter int WIDTH = 8
) (
    // Enables and flags of one group
    input wire logic [WIDTH-1:0] enables,
    input wire logic [WIDTH-1:0] flags,
    // Any enabled flag set
    output logic pending
);

    always_comb begin
        pending = |(enables & flags);
    end

endmodule // enabled_pending

// ==== verification/core_seq_model.sv ====
// Behavioural core sequencer that takes requests and returns from handlers
module core_seq_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Block side
    input wire logic irq_request,
    output logic irq_taken,
    output logic handler_return,
    // Bench control, lag 4'hF never takes
    input wire logic [3:0] lag,
    input wire logic ret_go
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_taken <= 1'b0;
            handler_return <= 1'b0;
            wait_reg <= 4'h0;
        end else begin
            handler_return <= ret_go;
            irq_taken <= 1'b0;
            wait_reg <= 4'h0;
            // Guard on irq_taken: request still stands in the take cycle
            if (irq_request && !irq_taken && lag != 4'hF) begin
                wait_reg <= wait_reg + 4'h1;
                irq_taken <= (wait_reg == lag);
            end
        end
    end
endmodule // core_seq_model

// ==== verification/interrupt_enable_control_monitor.sv ====
// Port-level checker for the interrupt enable block
module interrupt_enable_control_monitor
    import irq_enable_pkg::*;
(
    // Clock, reset and bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    // Sources and core
    input wire logic timer_zero_event,
    input wire logic pin_change_pending,
    input wire logic ext_pin_level,
    input wire periph_one_t periph_one_events,
    input wire periph_two_t periph_two_events,
    input wire logic irq_taken,
    input wire logic handler_return,
    input wire logic irq_request,
    input wire logic [15:0] irq_vector
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic rd_addr = hsel && hreadyout && htrans[1] && !hwrite;
    wire logic wr_addr = hsel && hreadyout && htrans[1] && hwrite;
    // ****
    // Properties
    // ****
    property p_vector; irq_vector == 16'h0004; endproperty
    a_vector: assert property (p_vector) else $error("vector moved");
    property p_reset; $rose(hresetn) |-> !irq_request; endproperty
    a_reset: assert property (p_reset) else $error("request after reset");
    property p_take; irq_request && irq_taken && !handler_return |=> !irq_request; endproperty
    a_take: assert property (p_take) else $error("take left request up");
    // A rise needs a flag event, a return, a write or a pending change
    property p_rise; $rose(irq_request) |-> $past(handler_return || timer_zero_event
        || (|periph_one_events) || (|periph_two_events)) || $past(wr_addr, 2)
        || ($past(ext_pin_level) != $past(ext_pin_level, 2)) || $rose(pin_change_pending);
    endproperty
    a_rise: assert property (p_rise) else $error("request rose without cause");
    property p_fall; $fell(irq_request) |-> $past(irq_taken) || $past(wr_addr, 2)
        || $fell(pin_change_pending); endproperty
    a_fall: assert property (p_fall) else $error("request fell without cause");
    property p_rdwait; rd_addr |=> !hreadyout ##1 hreadyout; endproperty
    a_rdwait: assert property (p_rdwait) else $error("read wait wrong");
    property p_ctl; rd_addr && haddr == 32'h0000_0000 |-> ##2 hrdata[5:1] == 5'h00; endproperty
    a_ctl: assert property (p_ctl) else $error("control gap bits set");
    property p_core; rd_addr && haddr == 32'h0000_0004 |-> ##2 hrdata[7:6] == 2'h0
        && hrdata[3:1] == 3'h0; endproperty
    a_core: assert property (p_core) else $error("core enable gap bits set");
    property p_upper; hreadyout |-> hrdata[31:8] == 24'h00_0000; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    c_take: cover property (irq_request && irq_taken);
    c_ret: cover property (handler_return);
    c_read: cover property (rd_addr);
endmodule // interrupt_enable_control_monitor

// ==== verification/interrupt_enable_control_tb_top.sv ====
// Self-checking bench for the interrupt enable block
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module interrupt_enable_control_tb_top
    import irq_enable_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ret_go = 1'b0;
    logic timer_zero_event = 1'b0, pin_change_pending = 1'b0, ext_pin_level = 1'b1;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
    periph_one_t periph_one_events = '0;
    periph_two_t periph_two_events = '0;
    logic [3:0] lag = 4'hF;
    logic hreadyout, hresp, irq_request, irq_taken, handler_return;
    logic [15:0] irq_vector;
    logic [7:0] rd8;
    int err_total = 0, cmp_count = 0;
    always #20 hclk = ~hclk;
    interrupt_enable_control uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .timer_zero_event, .pin_change_pending, .ext_pin_level, .periph_one_events,
        .periph_two_events, .irq_taken, .handler_return, .irq_request, .irq_vector);
    core_seq_model core (.hclk, .hresetn, .irq_request, .irq_taken, .handler_return,
        .lag, .ret_go);
    // ****
    // Bus and stimulus tasks
    // ****
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd8 = hrdata[7:0];
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        `CHK(rd8, e)
    endtask
    task automatic req_is(input logic e);
        @(posedge hclk);
        `CHK(irq_request, e)
    endtask
    task automatic fire(input int i);
        {periph_two_events, periph_one_events} <= 16'h0001 << i;
        @(posedge hclk);
        {periph_two_events, periph_one_events} <= 16'h0000;
        @(posedge hclk);
    endtask
    task automatic ext_to(input logic v);
        ext_pin_level <= v;
        @(posedge hclk);
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_regs;
        logic [7:0] exp_rb [8] = '{8'hC1, 8'h31, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
        rdchk(8'h00, 8'h01);
        for (int a = 4; a <= 28; a += 4) rdchk(8'(a), 8'h00);
        for (int a = 0; a <= 28; a += 4) wr(8'(a), 8'hFF);
        for (int a = 0; a <= 28; a += 4) rdchk(8'(a), exp_rb[a / 4]);
        wr(8'h00, 8'h3E);
        rdchk(8'h00, 8'h00);
        for (int a = 4; a < 16; a += 4) wr(8'(a), 8'h00);
    endtask
    task automatic t_gate;
        logic [15:0] en;
        for (int i = 0; i < 16; i++) begin
            en = 16'h0001 << i;
            wr(8'h08, en[7:0]);
            wr(8'h0C, en[15:8]);
            wr(8'h00, 8'hC1);
            fire(i ^ 1);
            req_is(1'b0);
            fire(i);
            req_is(1'b1);
            en = en | (16'h0001 << (i ^ 1));
            rdchk(8'h14, en[7:0]);
            rdchk(8'h18, en[15:8]);
            wr(8'h00, 8'h81);
            req_is(1'b0);
            wr(8'h00, 8'h41);
            req_is(1'b0);
            wr(8'h14, 8'hFF);
            wr(8'h18, 8'hFF);
        end
    endtask
    task automatic t_core;
        wr(8'h04, 8'h31);
        wr(8'h00, 8'h81);
        timer_zero_event <= 1'b1;
        @(posedge hclk);
        timer_zero_event <= 1'b0;
        req_is(1'b1);
        wr(8'h10, 8'h21);
        req_is(1'b0);
        pin_change_pending <= 1'b1;
        req_is(1'b1);
        rdchk(8'h10, 8'h10);
        pin_change_pending <= 1'b0;
        ext_to(1'b0);
        req_is(1'b0);
        ext_to(1'b1);
        req_is(1'b1);
        wr(8'h10, 8'h01);
        wr(8'h00, 8'h80);
        ext_to(1'b0);
        req_is(1'b1);
        wr(8'h04, 8'h30);
        req_is(1'b0);
        wr(8'h10, 8'h01);
        wr(8'h04, 8'h31);
        ext_to(1'b1);
        req_is(1'b0);
        wr(8'h04, 8'h00);
    endtask
    task automatic t_take;
        wr(8'h08, 8'h08);
        for (int k = 0; k < 2; k++) begin
            wr(8'h00, 8'hC1);
            lag <= 4'(k * 3);
            fire(3);
            for (int n = 0; n < 20 && irq_taken !== 1'b1; n++) @(posedge hclk);
            req_is(1'b0);
            `CHK(irq_vector, 16'h0004)
            lag <= 4'hF;
            rdchk(8'h00, 8'h41);
            wr(8'h14, 8'hFF);
            ret_go <= 1'b1;
            @(posedge hclk);
            ret_go <= 1'b0;
            repeat (2) @(posedge hclk);
            rdchk(8'h00, 8'hC1);
        end
    endtask
    task automatic finish_test;
        $display("comparisons=%0d mismatches=%0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_gate();
        t_core();
        t_take();
        finish_test();
    end
    // Run needs about 600 cycles
    initial begin
        #200000;
        err_total++;
        finish_test();
    end
endmodule // interrupt_enable_control_tb_top

bind interrupt_enable_control interrupt_enable_control_monitor mon (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hreadyout, .hrdata, .timer_zero_event, .pin_change_pending,
    .ext_pin_level, .periph_one_events, .periph_two_events, .irq_taken, .handler_return,
    .irq_request, .irq_vector);
